// ==== core/pintc_defines.vh ====
// register offsets, field positions, reset values of the interrupt controller
`ifndef PINTC_DEFINES_VH
`define PINTC_DEFINES_VH
`define PINTC_NSRC 16
`define PINTC_NEXT 5
`define PINTC_AW 8
`define PINTC_DW 16
`define PINTC_ADR_GC1 8'h00
`define PINTC_ADR_GC2 8'h01
`define PINTC_ADR_GC3 8'h02
`define PINTC_ADR_GC4 8'h03
`define PINTC_ADR_VEC 8'h04
`define PINTC_ADR_FLAG 8'h05
`define PINTC_ADR_ENA 8'h06
`define PINTC_ADR_PRI0 8'h08
`define PINTC_ADR_PRI1 8'h09
`define PINTC_ADR_PRI2 8'h0a
`define PINTC_ADR_PRI3 8'h0b
`define PINTC_ADR_SR 8'h0c
`define PINTC_ADR_CORE 8'h0d
`define PINTC_ADR_IST 8'h10
`define PINTC_ADR_ICLR 8'h11
`define PINTC_ADR_IEN 8'h12
`define PINTC_GC1_NEST 15
`define PINTC_GC1_TRAP_LO 1
`define PINTC_GC1_TRAP_HI 14
`define PINTC_GC2_GIE 15
`define PINTC_GC2_SWTRAP 13
`define PINTC_GC3_LO 4
`define PINTC_GC3_HI 6
`define PINTC_GC4_SWHT 0
`define PINTC_SR_IPL_LO 5
`define PINTC_SR_IPL_HI 7
`define PINTC_CORE_MSB 3
`define PINTC_VEC_BASE 8'h08
`define PINTC_RST_GC2 16'h8000
`define PINTC_RST_PRI 16'h4444
`define PINTC_IPL_MAX 3'h7
`endif

// ==== core/pintc_arbiter.v ====
// highest-priority pending source selection
`timescale 1ns/1ns
module pintc_arbiter (
   // requests and settings
   input wire [15:0] i_flag,
   input wire [15:0] i_enable,
   input wire [47:0] i_prio,
   input wire [3:0] i_cpu_level,
   // winner
   output reg o_valid,
   output reg [3:0] o_index,
   output reg [2:0] o_prio
);
   wire [15:0] elig;
   integer k;
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_src
         // zero priority never wins, must beat cpu level
         assign elig[g] = i_flag[g] & i_enable[g] &
            (i_prio[3*g+2:3*g] != 3'h0) &
            ({1'b0, i_prio[3*g+2:3*g]} > i_cpu_level);
      end
   endgenerate
   // scan downward with >= so the lower vector wins ties
   always @* begin
      o_valid = 1'b0;
      o_index = 4'h0;
      o_prio = 3'h0;
      for (k = 15; k >= 0; k = k - 1) begin
         if (elig[k] && (i_prio[3*k+2 -: 3] >= o_prio)) begin
            o_valid = 1'b1;
            o_index = k[3:0];
            o_prio = i_prio[3*k+2 -: 3];
         end
      end
   end
endmodule // pintc_arbiter

// ==== core/pintc_top.v ====
// prioritised vectored interrupt controller with register port
//
// Behaviour
// - control one holds nesting disable plus processor trap flags.
// - control two sets external request edge polarity and software trap.
// - control two holds global enable gating user interrupt delivery.
// - control three holds usb, dma and loop stack overflow trap flags.
// - control four holds the software generated hard trap status bit.
// - each source has a sticky request flag cleared only by software.
// - each source has its own enable bit.
// - each source has a programmable three bit priority.
// - vector register latches 8-bit vector and 4-bit new level.
// - latched new level equals priority of the pending source.
// - sources map to bits in vector order; source 0 is vector 8.
// - cpu status register holds low three level bits at 7:5.
// - software writes cpu level bits and the device honours them.
// - core control holds read-only level msb, so traps stay unmasked.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "pintc_defines.vh"
module pintc_top (
   // clock, reset, enable
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire i_clk_en,
   // register port
   input wire [7:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [15:0] o_rdata,
   // event sources
   input wire [15:0] i_periph_req,
   input wire [4:0] i_ext_pin,
   input wire [13:0] i_trap_evt,
   input wire [2:0] i_aux_trap_evt,
   // cpu side
   input wire i_irq_ack,
   output reg o_irq_req,
   output reg [7:0] o_vector,
   output reg [3:0] o_new_level,
   output reg o_trap,
   // controller interrupt
   output reg o_irq
);
   // control and status state
   reg nest_dis_q;
   reg [13:0] trap_flag_q;
   reg gie_q;
   reg sw_trap_q;
   reg [4:0] ext_pol_q;
   reg [2:0] aux_flag_q;
   reg sw_hard_q;
   reg [15:0] flag_q;
   reg [15:0] ena_q;
   reg [47:0] prio_q;
   reg [2:0] ipl_q;
   reg ipl_msb_q;
   reg [7:0] vec_q;
   reg [3:0] lvl_q;
   reg [2:0] ist_q;
   reg [2:0] ien_q;
   reg deliver_q;
   // external pin synchronisers
   reg [4:0] ext_s1_q;
   reg [4:0] ext_s2_q;
   reg [4:0] ext_s3_q;
   // reset words as vectors so single fields can be picked out
   localparam [15:0] rst_gc2_val = `PINTC_RST_GC2;
   localparam [15:0] rst_pri_val = `PINTC_RST_PRI;

   wire wr_gc1 = i_wr && (i_addr == `PINTC_ADR_GC1);
   wire wr_gc2 = i_wr && (i_addr == `PINTC_ADR_GC2);
   wire wr_gc3 = i_wr && (i_addr == `PINTC_ADR_GC3);
   wire wr_gc4 = i_wr && (i_addr == `PINTC_ADR_GC4);
   wire wr_flag = i_wr && (i_addr == `PINTC_ADR_FLAG);
   wire wr_ena = i_wr && (i_addr == `PINTC_ADR_ENA);
   wire wr_sr = i_wr && (i_addr == `PINTC_ADR_SR);
   wire wr_iclr = i_wr && (i_addr == `PINTC_ADR_ICLR);
   wire wr_ien = i_wr && (i_addr == `PINTC_ADR_IEN);

   // edge select: polarity bit 0 rising, 1 falling
   wire [4:0] ext_rise = ext_s2_q & ~ext_s3_q;
   wire [4:0] ext_fall = ~ext_s2_q & ext_s3_q;
   wire [4:0] ext_edge = (ext_rise & ~ext_pol_q) |
      (ext_fall & ext_pol_q);
   wire [15:0] flag_set = i_periph_req | {11'h000, ext_edge};

   // software trap request written this cycle
   wire sw_trap_go = wr_gc2 && i_wdata[`PINTC_GC2_SWTRAP];
   wire [3:0] cpu_level = {ipl_msb_q, ipl_q};

   wire arb_valid;
   wire [3:0] arb_index;
   wire [2:0] arb_prio;

   pintc_arbiter u_arb (
      .i_flag(flag_q),
      .i_enable(ena_q),
      .i_prio(prio_q),
      .i_cpu_level(cpu_level),
      .o_valid(arb_valid),
      .o_index(arb_index),
      .o_prio(arb_prio)
   );

   wire deliver_d = arb_valid & gie_q;
   wire trap_rise = (|i_trap_evt) | (|i_aux_trap_evt) | sw_trap_go;
   wire [2:0] ist_set = {sw_trap_go, trap_rise, deliver_d & ~deliver_q};
   wire any_trap = (|trap_flag_q) | (|aux_flag_q) | sw_hard_q;

   // pin synchronisers: first stage read only by second
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_s1_q <= 5'h00;
         ext_s2_q <= 5'h00;
         ext_s3_q <= 5'h00;
      end else if (i_clk_en) begin
         ext_s1_q <= i_ext_pin;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   // global control registers
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         nest_dis_q <= 1'b0;
         trap_flag_q <= 14'h0000;
         gie_q <= rst_gc2_val[`PINTC_GC2_GIE];
         sw_trap_q <= 1'b0;
         ext_pol_q <= 5'h00;
         aux_flag_q <= 3'h0;
         sw_hard_q <= 1'b0;
      end else if (i_clk_en) begin
         if (wr_gc1) begin
            nest_dis_q <= i_wdata[`PINTC_GC1_NEST];
         end
         // trap flags: hardware set wins over software clear
         trap_flag_q <= (wr_gc1 ?
            i_wdata[`PINTC_GC1_TRAP_HI:`PINTC_GC1_TRAP_LO] :
            trap_flag_q) | i_trap_evt;
         if (wr_gc2) begin
            gie_q <= i_wdata[`PINTC_GC2_GIE];
            sw_trap_q <= i_wdata[`PINTC_GC2_SWTRAP];
            ext_pol_q <= i_wdata[4:0];
         end
         aux_flag_q <= (wr_gc3 ?
            i_wdata[`PINTC_GC3_HI:`PINTC_GC3_LO] :
            aux_flag_q) | i_aux_trap_evt;
         sw_hard_q <= (wr_gc4 ? i_wdata[`PINTC_GC4_SWHT] : sw_hard_q) |
            sw_trap_go;
      end
   end

   // per-source flags, enables and priorities
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flag_q <= 16'h0000;
         ena_q <= 16'h0000;
         // packed three-bit fields, one per source
         prio_q <= {16{rst_pri_val[2:0]}};
      end else if (i_clk_en) begin
         flag_q <= (wr_flag ? i_wdata : flag_q) | flag_set;
         if (wr_ena) begin
            ena_q <= i_wdata;
         end
         if (i_wr) begin
            // one priority register per four sources
            case (i_addr)
               `PINTC_ADR_PRI0: begin
                  prio_q[11:0] <= {i_wdata[14:12], i_wdata[10:8],
                     i_wdata[6:4], i_wdata[2:0]};
               end
               `PINTC_ADR_PRI1: begin
                  prio_q[23:12] <= {i_wdata[14:12], i_wdata[10:8],
                     i_wdata[6:4], i_wdata[2:0]};
               end
               `PINTC_ADR_PRI2: begin
                  prio_q[35:24] <= {i_wdata[14:12], i_wdata[10:8],
                     i_wdata[6:4], i_wdata[2:0]};
               end
               `PINTC_ADR_PRI3: begin
                  prio_q[47:36] <= {i_wdata[14:12], i_wdata[10:8],
                     i_wdata[6:4], i_wdata[2:0]};
               end
               default: begin
                  prio_q <= prio_q;
               end
            endcase
         end
      end
   end

   // cpu priority level
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ipl_q <= 3'h0;
         ipl_msb_q <= 1'b0;
      end else if (i_clk_en) begin
         // acceptance raises the level; nesting disable forces maximum
         if (i_irq_ack && o_irq_req) begin
            ipl_q <= nest_dis_q ? `PINTC_IPL_MAX : lvl_q[2:0];
         end else if (wr_sr) begin
            ipl_q <= i_wdata[`PINTC_SR_IPL_HI:`PINTC_SR_IPL_LO];
         end
         // msb follows trap state only, no write path
         ipl_msb_q <= any_trap;
      end
   end

   // vector latch and cpu outputs
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         vec_q <= 8'h00;
         lvl_q <= 4'h0;
         deliver_q <= 1'b0;
         o_irq_req <= 1'b0;
         o_vector <= 8'h00;
         o_new_level <= 4'h0;
         o_trap <= 1'b0;
      end else if (i_clk_en) begin
         if (arb_valid) begin
            vec_q <= `PINTC_VEC_BASE + {4'h0, arb_index};
            lvl_q <= {1'b0, arb_prio};
         end else begin
            vec_q <= 8'h00;
            lvl_q <= 4'h0;
         end
         deliver_q <= deliver_d;
         o_irq_req <= deliver_d;
         o_vector <= arb_valid ? `PINTC_VEC_BASE + {4'h0, arb_index} :
            8'h00;
         o_new_level <= arb_valid ? {1'b0, arb_prio} : 4'h0;
         o_trap <= any_trap;
      end
   end

   // controller interrupt: set wins over clear
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ist_q <= 3'h0;
         ien_q <= 3'h0;
         o_irq <= 1'b0;
      end else if (i_clk_en) begin
         ist_q <= (ist_q & ~(wr_iclr ? i_wdata[2:0] : 3'h0)) | ist_set;
         if (wr_ien) begin
            ien_q <= i_wdata[2:0];
         end
         o_irq <= |(ist_q & ien_q);
      end
   end

   // read data valid only in the cycle after the strobe
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 16'h0000;
      end else if (i_clk_en) begin
         if (i_rd) begin
            case (i_addr)
               `PINTC_ADR_GC1: begin
                  o_rdata <= {nest_dis_q, trap_flag_q, 1'b0};
               end
               `PINTC_ADR_GC2: begin
                  o_rdata <= {gie_q, 1'b0, sw_trap_q, 8'h00,
                     ext_pol_q};
               end
               `PINTC_ADR_GC3: begin
                  o_rdata <= {9'h000, aux_flag_q, 4'h0};
               end
               `PINTC_ADR_GC4: begin
                  o_rdata <= {15'h0000, sw_hard_q};
               end
               `PINTC_ADR_VEC: begin
                  o_rdata <= {4'h0, lvl_q, vec_q};
               end
               `PINTC_ADR_FLAG: begin
                  o_rdata <= flag_q;
               end
               `PINTC_ADR_ENA: begin
                  o_rdata <= ena_q;
               end
               `PINTC_ADR_PRI0: begin
                  o_rdata <= {1'b0, prio_q[11:9], 1'b0, prio_q[8:6],
                     1'b0, prio_q[5:3], 1'b0, prio_q[2:0]};
               end
               `PINTC_ADR_PRI1: begin
                  o_rdata <= {1'b0, prio_q[23:21], 1'b0, prio_q[20:18],
                     1'b0, prio_q[17:15], 1'b0, prio_q[14:12]};
               end
               `PINTC_ADR_PRI2: begin
                  o_rdata <= {1'b0, prio_q[35:33], 1'b0, prio_q[32:30],
                     1'b0, prio_q[29:27], 1'b0, prio_q[26:24]};
               end
               `PINTC_ADR_PRI3: begin
                  o_rdata <= {1'b0, prio_q[47:45], 1'b0, prio_q[44:42],
                     1'b0, prio_q[41:39], 1'b0, prio_q[38:36]};
               end
               `PINTC_ADR_SR: begin
                  o_rdata <= {8'h00, ipl_q, 5'h00};
               end
               `PINTC_ADR_CORE: begin
                  o_rdata <= {12'h000, ipl_msb_q, 3'h0};
               end
               `PINTC_ADR_IST: begin
                  o_rdata <= {13'h0000, ist_q};
               end
               `PINTC_ADR_IEN: begin
                  o_rdata <= {13'h0000, ien_q};
               end
               default: begin
                  o_rdata <= 16'h0000;
               end
            endcase
         end else begin
            o_rdata <= 16'h0000;
         end
      end
   end
endmodule // pintc_top

// ==== dv/pintc_props.sv ====
// assertion checker on the interrupt controller ports
`timescale 1ns/1ns
module pintc_props (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   // cpu side
   input wire logic i_irq_ack,
   input wire logic o_irq_req,
   input wire logic [7:0] o_vector,
   input wire logic [3:0] o_new_level,
   input wire logic o_trap,
   input wire logic o_irq
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_ack;
      i_irq_ack && o_irq_req && i_clk_en ##1 i_clk_en;
   endsequence
   sequence s_trap;
      o_trap && i_clk_en ##1 o_trap && i_clk_en;
   endsequence
   sequence s_mask;
      i_wr && i_addr == 8'h12 && i_wdata == 16'h0000 && i_clk_en ##1 i_clk_en;
   endsequence
   chk_rd_idle: assert property (
      !$past(i_rd) && $past(i_clk_en) |-> o_rdata == 16'h0000)
      else $error("read data outside read slot");
   chk_req_level: assert property (
      o_irq_req |-> o_new_level inside {[4'h1:4'h7]})
      else $error("presented level out of range");
   chk_req_vector: assert property (
      o_irq_req |-> o_vector inside {[8'h08:8'h17]})
      else $error("presented vector out of range");
   chk_zero_level: assert property (
      o_new_level == 4'h0 |-> o_vector == 8'h00 && !o_irq_req)
      else $error("level zero presented");
   chk_trap_mask: assert property (s_trap |=> !o_irq_req)
      else $error("user request during trap");
   chk_ack_nest: assert property (
      s_ack |=> !o_irq_req || o_new_level > $past(o_new_level, 2))
      else $error("request not above acked level");
   chk_irq_mask: assert property (s_mask |=> !o_irq)
      else $error("irq high with all enables off");
   chk_clk_freeze: assert property (
      !i_clk_en |=> $stable(o_vector) && $stable(o_irq) && $stable(o_trap))
      else $error("outputs moved while frozen");
endmodule // pintc_props

// ==== dv/pintc_cpu_model.sv ====
// cpu model that accepts presented interrupts after a delay
`timescale 1ns/1ns
module pintc_cpu_model (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // control
   input wire logic i_auto,
   input wire logic [3:0] i_delay,
   // controller side
   input wire logic i_irq_req,
   output logic o_ack
);
   logic [3:0] cnt_q;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 4'h0;
         o_ack <= 1'b0;
      end else begin
         o_ack <= 1'b0;
         if (i_auto && i_irq_req && !o_ack) begin
            if (cnt_q >= i_delay) begin
               o_ack <= 1'b1;
               cnt_q <= 4'h0;
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end else begin
            cnt_q <= 4'h0;
         end
      end
   end
endmodule // pintc_cpu_model

// ==== dv/pintc_test.sv ====
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
module pintc_test;
   logic i_sys_clk, i_rst_n, i_clk_en, i_wr, i_rd, i_irq_ack, cpu_auto;
   logic o_irq_req, o_trap, o_irq;
   logic [7:0] i_addr, o_vector;
   logic [15:0] i_wdata, o_rdata, i_periph_req, v;
   logic [4:0] i_ext_pin;
   logic [13:0] i_trap_evt;
   logic [2:0] i_aux_trap_evt;
   logic [3:0] o_new_level;
   int n_errors, checks;
   pintc_top u_pintc_top (.i_sys_clk, .i_rst_n, .i_clk_en, .i_addr,
      .i_wdata, .i_wr, .i_rd, .o_rdata, .i_periph_req, .i_ext_pin,
      .i_trap_evt, .i_aux_trap_evt, .i_irq_ack, .o_irq_req, .o_vector,
      .o_new_level, .o_trap, .o_irq);
   pintc_cpu_model u_pintc_cpu_model (.i_sys_clk, .i_rst_n,
      .i_auto(cpu_auto), .i_delay(4'h2), .i_irq_req(o_irq_req),
      .o_ack(i_irq_ack));
   initial begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end
   task chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("Error %0t: got %h expected %h", $time, s, e);
      end
   endtask
   function logic [15:0] cpu();
      return {o_irq_req, 3'h0, o_new_level, o_vector};
   endfunction
   task cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_sys_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_sys_clk) i_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge i_sys_clk) {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_sys_clk) i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   task pulse(input logic [15:0] m);
      @(posedge i_sys_clk) i_periph_req <= m;
      @(posedge i_sys_clk) i_periph_req <= 16'h0000;
   endtask
   task t_reset;
      logic [7:0] ra[8];
      logic [15:0] rv[8];
      ra = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h1f};
      rv = '{16'h0, 16'h8000, 16'h4444, 16'h4444, 16'h4444, 16'h4444,
         16'h0, 16'h0};
      for (int i = 0; i < 8; i++) begin
         rd(ra[i]);
         chk(v, rv[i]);
      end
   endtask
   task t_arb;
      wr(8'h06, 16'h0022);
      pulse(16'h0022);
      cyc(3);
      chk(cpu(), 16'h8409);
      rd(8'h04);
      chk(v, 16'h0409);
      wr(8'h09, 16'h4464);
      cyc(2);
      chk(cpu(), 16'h860d);
      wr(8'h06, 16'h0002);
      cyc(2);
      chk(cpu(), 16'h8409);
      wr(8'h08, 16'h4404);
      cyc(2);
      chk(cpu(), 16'h0000);
      rd(8'h05);
      chk(v, 16'h0022);
      wr(8'h05, 16'h0000);
      rd(8'h05);
      chk(v, 16'h0000);
      wr(8'h08, 16'h4444);
      wr(8'h09, 16'h4444);
   endtask
   task t_level;
      wr(8'h06, 16'h0001);
      wr(8'h0c, 16'h0080);
      pulse(16'h0001);
      cyc(3);
      chk(cpu(), 16'h0000);
      rd(8'h0c);
      chk(v, 16'h0080);
      wr(8'h0c, 16'h0060);
      cyc(2);
      chk(cpu(), 16'h8408);
      wr(8'h0c, 16'h0000);
      wr(8'h05, 16'h0000);
   endtask
   task t_ack;
      @(posedge i_sys_clk) cpu_auto <= 1'b1;
      pulse(16'h0001);
      cyc(10);
      rd(8'h0c);
      chk(v, 16'h0080);
      chk(cpu(), 16'h0000);
      @(posedge i_sys_clk) cpu_auto <= 1'b0;
      wr(8'h00, 16'h8000);
      wr(8'h0c, 16'h0000);
      @(posedge i_sys_clk) cpu_auto <= 1'b1;
      cyc(10);
      rd(8'h0c);
      chk(v, 16'h00e0);
      @(posedge i_sys_clk) cpu_auto <= 1'b0;
      wr(8'h00, 16'h0000);
      wr(8'h0c, 16'h0000);
      wr(8'h05, 16'h0000);
   endtask
   task t_irq;
      wr(8'h11, 16'h0007);
      wr(8'h12, 16'h0001);
      rd(8'h10);
      chk(v, 16'h0000);
      pulse(16'h0001);
      cyc(4);
      rd(8'h10);
      chk(v, 16'h0001);
      chk({15'h0, o_irq}, 16'h0001);
      wr(8'h12, 16'h0000);
      cyc(2);
      chk({15'h0, o_irq}, 16'h0000);
      wr(8'h12, 16'h0001);
      cyc(2);
      chk({15'h0, o_irq}, 16'h0001);
      wr(8'h11, 16'h0001);
      cyc(2);
      chk({15'h0, o_irq}, 16'h0000);
      wr(8'h05, 16'h0000);
   endtask
   task t_trap;
      @(posedge i_sys_clk) {i_trap_evt, i_aux_trap_evt} <= {14'h1, 3'h7};
      @(posedge i_sys_clk) {i_trap_evt, i_aux_trap_evt} <= 17'h0;
      cyc(3);
      rd(8'h00);
      chk(v, 16'h0002);
      rd(8'h02);
      chk(v, 16'h0070);
      wr(8'h0d, 16'h0000);
      rd(8'h0d);
      chk(v, 16'h0008);
      chk({15'h0, o_trap}, 16'h0001);
      wr(8'h01, 16'ha000);
      rd(8'h03);
      chk(v, 16'h0001);
      rd(8'h10);
      chk(v, 16'h0006);
      wr(8'h00, 16'h0000);
      wr(8'h02, 16'h0000);
      wr(8'h03, 16'h0000);
      wr(8'h01, 16'h8000);
   endtask
   task t_ext;
      @(posedge i_sys_clk) i_ext_pin <= 5'h04;
      cyc(8);
      rd(8'h05);
      chk(v, 16'h0004);
      @(posedge i_sys_clk) i_clk_en <= 1'b0;
      @(posedge i_sys_clk) i_clk_en <= 1'b1;
      wr(8'h06, 16'h0004);
      cyc(2);
      chk(cpu(), 16'h840a);
      wr(8'h01, 16'h0000);
      cyc(2);
      chk(cpu(), 16'h040a);
      wr(8'h01, 16'h8000);
      wr(8'h05, 16'h0000);
      wr(8'h01, 16'h8004);
      @(posedge i_sys_clk) i_ext_pin <= 5'h00;
      cyc(8);
      rd(8'h05);
      chk(v, 16'h0004);
      wr(8'h01, 16'h8000);
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      {i_rst_n, i_clk_en, i_wr, i_rd, cpu_auto} = 5'h08;
      {i_addr, i_wdata, i_periph_req, i_ext_pin} = 45'h0;
      {i_trap_evt, i_aux_trap_evt} = 17'h0;
      repeat (20) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      t_reset;
      t_arb;
      t_level;
      t_ack;
      t_irq;
      t_trap;
      t_ext;
      end_of_test;
   end
   initial begin
      repeat (4000) @(posedge i_sys_clk);
      n_errors++;
      end_of_test;
   end
endmodule // pintc_test
bind pintc_top pintc_props u_pintc_props (.i_sys_clk, .i_rst_n, .i_clk_en,
   .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_irq_ack, .o_irq_req,
   .o_vector, .o_new_level, .o_trap, .o_irq);
